// file: inc/cer_pkg.sv
// constants, register map and record layout of the camera event reporter
// assumes a single 100 MHz clock and an AXI4-Lite register master
package cer_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TICK_NS = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // queue and record layout
  localparam int unsigned QDEPTH_DEF = 16;
  localparam int unsigned REC_W = 128;
  localparam int unsigned REC_WORDS = 4;
  localparam logic [15:0] TYPE_EXP_END = 16'h0001;
  localparam logic [15:0] TYPE_OVERRUN = 16'h0002;
  localparam logic [15:0] CHANNEL_ID = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_TIMEOUT = 6'h04;
  localparam logic [5:0] OFS_RETRY = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h0C;
  localparam logic [5:0] OFS_MASK = 6'h10;
  localparam logic [5:0] OFS_STATE = 6'h14;

  localparam int unsigned CTRL_EXP_EN = 0;
  localparam int unsigned CTRL_OVR_EN = 1;

  localparam int unsigned ST_SENT = 0;
  localparam int unsigned ST_ACKED = 1;
  localparam int unsigned ST_DROPPED = 2;
  localparam int unsigned ST_OVERRUN = 3;
  localparam int unsigned ST_W = 4;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_1000;
  localparam logic [7:0] RETRY_RST = 8'h03;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////////
  // message sequencer
  typedef enum logic [2:0] {
    CER_IDLE = 3'b000,
    CER_HDR = 3'b001,
    CER_FETCH = 3'b010,
    CER_WORDS = 3'b011,
    CER_WAIT = 3'b100
  } cer_state_e;

endpackage

// file: hdl/cer_queue_mem.sv
// record storage of the event queue
// assumes one write and one read port, read data one cycle after rd_en
`timescale 1ns/1ps
module cer_queue_mem #(
  parameter int unsigned W = 128,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// file: hdl/cer_event_reporter.sv
// camera event reporter: record builder, queue, message sender, registers
// assumes exposure_end is a one-cycle pulse and ack_in a one-cycle pulse
`timescale 1ns/1ps
module cer_event_reporter #(
  parameter int unsigned QDEPTH = cer_pkg::QDEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic exposure_end,
  input wire logic [31:0] frame_count,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [5:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_data,
  output logic tx_last,
  input wire logic ack_in,
  output logic irq
);
  import cer_pkg::*;

  localparam int unsigned AW = $clog2(QDEPTH);
  localparam int unsigned CW = $clog2(QDEPTH + 1);
  localparam logic [CW-1:0] FULL_N = CW'(QDEPTH);
  localparam logic [CW-1:0] NORMAL_N = CW'(QDEPTH - 1);

  if (QDEPTH < 2 || (1 << AW) != QDEPTH) begin : g_chk
    $error("QDEPTH must be a power of two of at least 2");
  end

  function automatic logic [31:0] cer_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // timestamp: 8 ns ticks accumulated from 10 ns clock periods
  logic [63:0] ts_q, ts_d;
  logic [2:0] ts_res_q, ts_res_d;
  logic [4:0] ts_sum;

  always_comb begin
    ts_sum = 5'(ts_res_q) + 5'(CLK_NS);
    ts_d = ts_q + 64'(ts_sum / 5'(TICK_NS));
    ts_res_d = 3'(ts_sum % 5'(TICK_NS));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ts_q <= '0;
      ts_res_q <= '0;
    end else begin
      ts_q <= ts_d;
      ts_res_q <= ts_res_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and state shared below
  logic [31:0] ctrl_q, ctrl_d, tmo_q, tmo_d;
  logic [7:0] rty_q, rty_d;
  logic [ST_W-1:0] status_q, status_d, mask_q, mask_d, st_set;
  logic irq_q, irq_d;
  cer_state_e state_q, state_d;
  logic [CW-1:0] count_q, count_d, nmsg_q, nmsg_d, rec_i_q, rec_i_d;
  logic [AW-1:0] head_q, head_d, tail_q, tail_d;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////////
  // record builder and queue pointers
  logic wants_exp, drop, ovr_rec, wr_en;
  logic [REC_W-1:0] wr_data, rd_data;
  logic rd_en;

  always_comb begin
    wants_exp = exposure_end && ctrl_q[CTRL_EXP_EN];
    drop = wants_exp && (count_q >= NORMAL_N);
    ovr_rec = drop && ctrl_q[CTRL_OVR_EN] && (count_q < FULL_N);
    wr_en = (wants_exp && !drop) || ovr_rec;
    wr_data = {(drop ? TYPE_OVERRUN : TYPE_EXP_END), CHANNEL_ID,
               frame_count, ts_q};
    tail_d = tail_q + AW'(wr_en);
    head_d = pop ? head_q + AW'(nmsg_q) : head_q;
    count_d = count_q + CW'(wr_en) - (pop ? nmsg_q : '0);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      head_q <= '0;
      tail_q <= '0;
      count_q <= '0;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      count_q <= count_d;
    end
  end

  cer_queue_mem #(.W(REC_W), .DEPTH(QDEPTH)) u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_addr(tail_q),
    .wr_data(wr_data),
    .rd_en(rd_en),
    .rd_addr(head_q + AW'(rec_i_q)),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // message sequencer
  logic [1:0] word_q, word_d;
  logic [31:0] tmr_q, tmr_d;
  logic [7:0] tries_q, tries_d;
  logic txv_q, txv_d, txl_q, txl_d, slot;
  logic [31:0] txd_q, txd_d;

  always_comb begin
    state_d = state_q;
    nmsg_d = nmsg_q;
    rec_i_d = rec_i_q;
    word_d = word_q;
    tmr_d = tmr_q;
    tries_d = tries_q;
    txv_d = txv_q && !tx_ready;
    txd_d = txd_q;
    txl_d = txl_q;
    slot = !txv_q || tx_ready;
    rd_en = 1'b0;
    pop = 1'b0;
    st_set = '0;
    st_set[ST_OVERRUN] = drop;
    unique case (state_q)
      CER_IDLE: begin
        if (count_q != '0 && (ctrl_q[CTRL_EXP_EN] || ctrl_q[CTRL_OVR_EN])) begin
          nmsg_d = count_q;
          tries_d = '0;
          state_d = CER_HDR;
        end
      end
      CER_HDR: begin
        if (slot) begin
          txv_d = 1'b1;
          txd_d = 32'(nmsg_q);
          txl_d = 1'b0;
          rec_i_d = '0;
          st_set[ST_SENT] = 1'b1;
          state_d = CER_FETCH;
        end
      end
      CER_FETCH: begin
        rd_en = 1'b1;
        word_d = '0;
        state_d = CER_WORDS;
      end
      CER_WORDS: begin
        if (slot) begin
          txv_d = 1'b1;
          txd_d = rd_data[REC_W-1-32*word_q -: 32];
          txl_d = (word_q == 2'(REC_WORDS - 1)) && (rec_i_q == nmsg_q - 1'b1);
          word_d = word_q + 1'b1;
          if (word_q == 2'(REC_WORDS - 1)) begin
            rec_i_d = rec_i_q + 1'b1;
            tmr_d = '0;
            state_d = (rec_i_q == nmsg_q - 1'b1) ? CER_WAIT : CER_FETCH;
          end
        end
      end
      CER_WAIT: begin
        if (ack_in) begin
          pop = 1'b1;
          st_set[ST_ACKED] = 1'b1;
          state_d = CER_IDLE;
        end else if (!txv_q) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q >= tmo_q) begin
            if (tries_q >= rty_q) begin
              pop = 1'b1;
              st_set[ST_DROPPED] = 1'b1;
              state_d = CER_IDLE;
            end else begin
              tries_d = tries_q + 1'b1;
              state_d = CER_HDR;
            end
          end
        end
      end
      default: state_d = CER_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= CER_IDLE;
      nmsg_q <= '0;
      rec_i_q <= '0;
      word_q <= '0;
      tmr_q <= '0;
      tries_q <= '0;
      txv_q <= 1'b0;
      txd_q <= '0;
      txl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      nmsg_q <= nmsg_d;
      rec_i_q <= rec_i_d;
      word_q <= word_d;
      tmr_q <= tmr_d;
      tries_q <= tries_d;
      txv_q <= txv_d;
      txd_q <= txd_d;
      txl_q <= txl_d;
    end
  end

  assign tx_valid = txv_q;
  assign tx_data = txd_q;
  assign tx_last = txl_q;

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic [5:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic do_wr;

  always_comb begin
    awr_d = awr_q;
    wr_d = wr_q;
    bv_d = bv_q;
    br_d = br_q;
    arr_d = arr_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    ctrl_d = ctrl_q;
    tmo_d = tmo_q;
    rty_d = rty_q;
    mask_d = mask_q;
    status_d = status_q;
    if (s_axi_awvalid && awr_q) begin
      awa_d = s_axi_awaddr;
      awr_d = 1'b0;
    end
    if (s_axi_wvalid && wr_q) begin
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
      wr_d = 1'b0;
    end
    do_wr = !awr_q && !wr_q && !bv_q;
    if (do_wr) begin
      bv_d = 1'b1;
      br_d = RESP_OKAY;
      unique case ({awa_q[5:2], 2'b00})
        OFS_CTRL: ctrl_d = cer_merge(ctrl_q, wd_q, ws_q) & 32'h0000_0003;
        OFS_TIMEOUT: tmo_d = cer_merge(tmo_q, wd_q, ws_q);
        OFS_RETRY: rty_d = ws_q[0] ? wd_q[7:0] : rty_q;
        OFS_STATUS: status_d = ws_q[0] ? status_q & ~wd_q[ST_W-1:0] : status_q;
        OFS_MASK: mask_d = ws_q[0] ? wd_q[ST_W-1:0] : mask_q;
        OFS_STATE: br_d = RESP_OKAY;
        default: br_d = RESP_SLVERR;
      endcase
    end
    status_d = status_d | st_set;
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
      awr_d = 1'b1;
      wr_d = 1'b1;
    end
    if (s_axi_arvalid && arr_q) begin
      arr_d = 1'b0;
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      unique case ({s_axi_araddr[5:2], 2'b00})
        OFS_CTRL: rd_d = ctrl_q;
        OFS_TIMEOUT: rd_d = tmo_q;
        OFS_RETRY: rd_d = 32'(rty_q);
        OFS_STATUS: rd_d = 32'(status_q);
        OFS_MASK: rd_d = 32'(mask_q);
        OFS_STATE: rd_d = {13'h0000, state_q, 8'(tries_q), 8'(count_q)};
        default: begin
          rd_d = '0;
          rr_d = RESP_SLVERR;
        end
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
      arr_d = 1'b1;
    end
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      bv_q <= 1'b0;
      br_q <= RESP_OKAY;
      arr_q <= 1'b1;
      rv_q <= 1'b0;
      rd_q <= '0;
      rr_q <= RESP_OKAY;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      ctrl_q <= CTRL_RST;
      tmo_q <= TIMEOUT_RST;
      rty_q <= RETRY_RST;
      mask_q <= MASK_RST;
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      awr_q <= awr_d;
      wr_q <= wr_d;
      bv_q <= bv_d;
      br_q <= br_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      ctrl_q <= ctrl_d;
      tmo_q <= tmo_d;
      rty_q <= rty_d;
      mask_q <= mask_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  assign irq = irq_q;
endmodule

// file: dv/cer_host_model.sv
// host side: takes message words, acknowledges each message while ack_en is set
// assumes header word = record count, then four words per record
`timescale 1ns/1ps
module cer_host_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  input wire logic ack_en,
  output logic tx_ready,
  output logic ack_in
);
  int seed = 72556;
  int n_w = 0;
  int hdr = 0;
  int msgs = 0;
  int bad = 0;
  int dly = 0;
  logic [127:0] rec;
  logic [127:0] rec_q[$];

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      ack_in <= 1'b0;
      n_w = 0;
      dly = 0;
    end else begin
      tx_ready <= ($random(seed) & 3) != 0;
      ack_in <= dly == 1;
      if (dly > 0) dly--;
      if (tx_valid && tx_ready) begin
        if (n_w > 0) rec = {rec[95:0], tx_data};
        else hdr = tx_data;
        if (n_w > 0 && n_w % 4 == 0) rec_q.push_back(rec);
        n_w++;
        if (tx_last) begin
          bad += n_w != 4 * hdr + 1;
          n_w = 0;
          msgs++;
          if (ack_en) dly = 3;
        end
      end
    end
  end
endmodule

// file: dv/cer_event_reporter_asserts.sv
// port checker of the event reporter
// assumes it is bound into cer_event_reporter
`timescale 1ns/1ps
module cer_event_reporter_asserts #(
  parameter int unsigned QDEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  input wire logic irq
);
  import cer_pkg::*;
  logic exp_on_q, aw_ctrl_q, ctrl_hit;
  default clocking cb @(posedge clk_sys); endclocking
  // control write that turns exposure reporting on, aw taken before or with w
  assign ctrl_hit = (s_axi_awvalid && s_axi_awready) ? (s_axi_awaddr[5:2] == OFS_CTRL[5:2])
                                                      : aw_ctrl_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_ctrl_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ctrl_q <= s_axi_awaddr[5:2] == OFS_CTRL[5:2];
    end
    exp_on_q <= rst_n && (exp_on_q || (s_axi_wvalid && s_axi_wready && ctrl_hit &&
                                      s_axi_wdata[CTRL_EXP_EN]));
  end
  sequence s_last_taken;
    tx_valid && tx_ready && tx_last;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_tx_hold: assert property (disable iff (!rst_n)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx word changed while stalled");
  a_wait_quiet: assert property (disable iff (!rst_n)
    s_last_taken |=> !tx_valid [*2]) else $error("tx started during wait");
  a_off_silent: assert property (disable iff (!rst_n)
    !exp_on_q |-> !tx_valid) else $error("tx before exposure reporting enabled");
  a_rst_quiet: assert property (
    !rst_n |=> !tx_valid && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active in reset");
  a_b_hold: assert property (disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_answer: assert property (disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  a_w_answer: assert property (disable iff (!rst_n)
    s_wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
endmodule

bind cer_event_reporter cer_event_reporter_asserts #(.QDEPTH(QDEPTH)) u_asserts (
  .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
  .s_axi_wready, .s_axi_wdata,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tx_valid, .tx_ready, .tx_data,
  .tx_last, .irq);

// file: dv/test_cer_event_reporter.sv
// self-checking bench of the event reporter
// assumes the host model on the tx side
`timescale 1ns/1ps
module test_cer_event_reporter;
  import cer_pkg::*;
  logic clk_sys = 0;
  logic rst_n = 0;
  logic exposure_end = 0;
  logic [31:0] frame_count = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic tx_valid, tx_ready, tx_last, ack_in, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, tx_data, rd;
  logic ack_en = 0;
  int failures = 0, num_checks = 0, seed = 72556, i;
  logic [47:0] exp_q[$];
  always #5 clk_sys = ~clk_sys;

  cer_event_reporter #(.QDEPTH(4)) u_dut (
    .clk_sys, .rst_n, .exposure_end, .frame_count, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .tx_valid, .tx_ready, .tx_data, .tx_last, .ack_in, .irq);
  cer_host_model u_host (
    .clk_sys, .rst_n, .tx_valid, .tx_data, .tx_last, .ack_en, .tx_ready, .ack_in);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n > 3000) begin
      chk(0, 1);
      close_out();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys);
      tmo(++n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bready && s_axi_bvalid) begin
        s_axi_bready <= 0;
        chk(s_axi_bresp, e);
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rdt(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] er);
    int n;
    n = 0;
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    do begin
      @(posedge clk_sys);
      tmo(++n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rready && s_axi_rvalid) begin
        s_axi_rready <= 0;
        chk(s_axi_rdata & m, e);
        chk(s_axi_rresp, er);
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  task automatic ev(input logic [31:0] f, input int gap);
    exposure_end <= 1;
    frame_count <= f;
    @(posedge clk_sys);
    if (gap > 0) begin
      exposure_end <= 0;
      repeat (gap) @(posedge clk_sys);
    end
  endtask
  task automatic drain(input int k);
    int n;
    n = 0;
    while (u_host.rec_q.size() < k) begin
      @(posedge clk_sys);
      tmo(++n);
    end
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic cmp;
    logic [47:0] e;
    logic [127:0] r;
    chk(u_host.bad, 0);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      r = u_host.rec_q.pop_front();
      if (e[47:32] === TYPE_OVERRUN) chk(r[127:96], {TYPE_OVERRUN, CHANNEL_ID});
      else chk(r[127:64], {e[47:32], CHANNEL_ID, e[31:0]});
    end
    u_host.rec_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1;
    rdt(OFS_CTRL, CTRL_RST, 32'hFFFF_FFFF, RESP_OKAY);
    rdt(OFS_TIMEOUT, TIMEOUT_RST, 32'hFFFF_FFFF, RESP_OKAY);
    rdt(OFS_RETRY, {24'h00_0000, RETRY_RST}, 32'h0000_00FF, RESP_OKAY);
    rdt(OFS_MASK, {28'h000_0000, MASK_RST}, 32'h0000_000F, RESP_OKAY);
    rdt(6'h18, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(6'h1C, 32'h0000_00FF, RESP_SLVERR);
    // exposure type disabled: nothing queued or sent
    wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
    ev(32'h0000_0011, 30);
    chk(u_host.msgs, 0);
    rdt(OFS_STATE, 32'h0000_0000, 32'h0000_00FF, RESP_OKAY);
    wr(OFS_TIMEOUT, 32'h0000_0014, RESP_OKAY);
    wr(OFS_RETRY, 32'h0000_0001, RESP_OKAY);
    wr(OFS_MASK, 32'h0000_000F, RESP_OKAY);
    ack_en <= 1;
    wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      rd = $random(seed);
      exp_q.push_back({TYPE_EXP_END, rd});
      ev(rd, 15);
    end
    drain(4);
    chk(u_host.rec_q[1][63:0] - u_host.rec_q[0][63:0], 64'h0000_0000_0000_0014);
    cmp();
    rdt(OFS_STATUS, 32'h0000_0003, 32'h0000_0003, RESP_OKAY);
    chk(irq, 1);
    wr(OFS_STATUS, 32'h0000_000F, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0);
    // no acknowledge: one resend, then dropped
    ack_en <= 0;
    ev(32'h0000_0077, 60);
    drain(2);
    chk(u_host.rec_q[1][95:64], 32'h0000_0077);
    repeat (40) @(posedge clk_sys);
    chk(u_host.rec_q.size(), 2);
    rdt(OFS_STATUS, 32'h0000_0004, 32'h0000_0004, RESP_OKAY);
    rdt(OFS_STATE, 32'h0000_0000, 32'h0000_00FF, RESP_OKAY);
    u_host.rec_q.delete();
    // burst into a queue of four: overrun record in the reserved slot
    ack_en <= 1;
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    for (i = 0; i < 5; i++) begin
      rd = $random(seed);
      if (i < 3) exp_q.push_back({TYPE_EXP_END, rd});
      ev(rd, 0);
    end
    exposure_end <= 0;
    exp_q.push_back({TYPE_OVERRUN, 32'h0000_0000});
    drain(4);
    chk(u_host.rec_q.size(), 4);
    cmp();
    rdt(OFS_STATUS, 32'h0000_0008, 32'h0000_0008, RESP_OKAY);
    close_out();
  end
endmodule
